// file: rtl/dual_field_pixel.sv
// Module: dual-field colour priority pixel path with AHB-Lite registers
//
// Overview of operation
// [RULE_01] Control zero bit 10 selects dual-field grouping and per-field shifting; the code applies the per-field scroll delays with the bit clear too.
// [RULE_02] Odd planes 1,3,5 form field one; even planes 2,4,6 form field two.
// [RULE_03] Each field uses one to three planes per configured plane count.
// [RULE_04] High resolution dual-field limits each field to two planes.
// [RULE_05] Field one index has plane 5 as MSB; 1..7 select entries 1..7.
// [RULE_06] Field two index has plane 6 as MSB; 1..7 select entries 9..15.
// [RULE_07] Zero index is transparent; whatever lies behind shows.
// [RULE_08] High resolution: field one entries 1..3, field two entries 9..11.
// [RULE_09] Control two bit 6 set puts field two in front.
// [RULE_10] One fetch window begin and end shared by both fields.
// [RULE_11] Each field has its own horizontal scroll delay.
// [RULE_12] Each field keeps its own pointer and line skip.
// [RULE_13] Software widens the fetch window when scrolling a field.
// [RULE_14] Software offsets the stationary field's pointer and skip.
// [RULE_15] Vertical position read bit 15 reports the long-frame flag.
// [RULE_16] Separate line-skip registers for odd and even planes.
// [RULE_17] Both fields transparent and no object gives palette entry 0.
// [RULE_18] Dual-field off combines all enabled planes into one index; the code uses planes 1..5 only and drops plane 6.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
module dual_field_pixel #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        plane_valid,
  output logic             plane_ready,
  input  wire logic [5:0]  plane_bits,
  input  wire logic        object_valid,
  input  wire logic [4:0]  object_index,
  input  wire logic        line_end,
  input  wire logic        frame_end,
  output logic             pixel_valid,
  output logic [4:0]       pixel_index,
  output logic [31:0]      odd_fetch_addr,
  output logic [31:0]      even_fetch_addr,
  output logic [8:0]       fetch_begin,
  output logic [8:0]       fetch_end
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctl0;
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic [15:0] fbegin;
    logic [15:0] fend;
    logic [15:0] odd_skip;
    logic [15:0] even_skip;
    logic [31:0] odd_ptr;
    logic [31:0] even_ptr;
    logic [31:0] odd_cur;
    logic [31:0] even_cur;
    logic        long_frame_flag;
    logic [14:0] vpos;
    logic        a_pend;
    logic        a_write;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
    logic [17:0] odd_dly;
    logic [17:0] even_dly;
    logic        pvalid;
    logic [4:0]  pindex;
    dual_field_pkg::pix_state_e st;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  // ------------------------------------------------------------
  // Plane word buffer
  // ------------------------------------------------------------
  pixel_stream_if #(.WIDTH(6)) pix ();

  plane_fifo #(
    .WIDTH (6),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .in_valid (plane_valid),
    .in_ready (plane_ready),
    .in_data  (plane_bits),
    .out      (pix)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [5:0] plane_mask(input logic [2:0] cnt, input logic hi);
    logic [5:0] m;
    logic [2:0] c;
    m = 6'h00;
    c = (cnt > 3'(dual_field_pkg::plane_max)) ? 3'(dual_field_pkg::plane_max) : cnt;
    if (hi && c > 3'h4) begin
      c = 3'h4; // RULE_04
    end
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < c) begin
        m[i] = 1'b1; // RULE_03
      end
    end
    return m;
  endfunction : plane_mask

  function automatic logic [2:0] scroll_pick(input logic [17:0] dl, input logic [3:0] amt);
    logic [2:0] v;
    v = 3'h0;
    case (amt[1:0])
      2'h0: v = dl[2:0];
      2'h1: v = dl[5:3];
      2'h2: v = dl[8:6];
      default: v = dl[11:9];
    endcase
    return v;
  endfunction : scroll_pick

  function automatic logic [4:0] layer_pick(input logic [4:0] near, input logic [4:0] far);
    logic [4:0] v;
    v = 5'h00;
    if (near[2:0] != 3'h0) begin
      v = near;
    end else if (far[2:0] != 3'h0) begin
      v = far;
    end
    return v;
  endfunction : layer_pick

  function automatic logic [31:0] skip_extend(input logic [15:0] s);
    logic [31:0] v;
    v = {{16{s[15]}}, s};
    return v;
  endfunction : skip_extend

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [5:0] planes;
    logic [2:0] odd_now;
    logic [2:0] even_now;
    logic [2:0] f1;
    logic [2:0] f2;
    logic [4:0] c1;
    logic [4:0] c2;
    logic [4:0] front;
    logic       hi;
    logic       dual;
    logic       wr_go;
    planes   = 6'h00;
    odd_now  = 3'h0;
    even_now = 3'h0;
    f1       = 3'h0;
    f2       = 3'h0;
    c1       = 5'h00;
    c2       = 5'h00;
    front    = 5'h00;
    nxt_cur  = cur_ff;
    hi       = cur_ff.ctl0[dual_field_pkg::hires_bit];
    dual     = cur_ff.ctl0[dual_field_pkg::dual_field_select_bit];
    wr_go    = cur_ff.a_pend && cur_ff.a_write;

    // ----------------------------------------------------------
    // Register write, data phase
    // ----------------------------------------------------------
    if (wr_go) begin
      case (cur_ff.a_addr)
        dual_field_pkg::plane_control_zero_addr:   nxt_cur.ctl0 = hwdata[15:0]; // RULE_01
        dual_field_pkg::plane_control_one_addr:    nxt_cur.ctl1 = hwdata[15:0]; // RULE_11
        dual_field_pkg::plane_control_two_addr:    nxt_cur.ctl2 = hwdata[15:0]; // RULE_09
        dual_field_pkg::fetch_window_begin_addr:   nxt_cur.fbegin = hwdata[15:0]; // RULE_10
        dual_field_pkg::fetch_window_end_addr:     nxt_cur.fend = hwdata[15:0]; // RULE_10
        dual_field_pkg::odd_plane_line_skip_addr:  nxt_cur.odd_skip = hwdata[15:0]; // RULE_16
        dual_field_pkg::even_plane_line_skip_addr: nxt_cur.even_skip = hwdata[15:0]; // RULE_16
        dual_field_pkg::odd_field_pointer_addr: begin
          nxt_cur.odd_ptr = {hwdata[31:1], 1'b0}; // RULE_12
          nxt_cur.odd_cur = {hwdata[31:1], 1'b0};
        end
        dual_field_pkg::even_field_pointer_addr: begin
          nxt_cur.even_ptr = {hwdata[31:1], 1'b0}; // RULE_12
          nxt_cur.even_cur = {hwdata[31:1], 1'b0};
        end
        dual_field_pkg::frame_control_addr: begin
          if (hwdata[dual_field_pkg::frame_toggle_bit]) begin
            nxt_cur.long_frame_flag = ~cur_ff.long_frame_flag;
          end
        end
        default: nxt_cur.a_pend = 1'b0;
      endcase
    end

    // ----------------------------------------------------------
    // Register address phase and read data
    // ----------------------------------------------------------
    nxt_cur.a_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      nxt_cur.a_pend  = 1'b1;
      nxt_cur.a_write = hwrite;
      nxt_cur.a_addr  = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        case ({haddr[7:2], 2'b00})
          dual_field_pkg::plane_control_zero_addr:   nxt_cur.rdata = {16'h0000, cur_ff.ctl0};
          dual_field_pkg::plane_control_one_addr:    nxt_cur.rdata = {16'h0000, cur_ff.ctl1};
          dual_field_pkg::plane_control_two_addr:    nxt_cur.rdata = {16'h0000, cur_ff.ctl2};
          dual_field_pkg::fetch_window_begin_addr:   nxt_cur.rdata = {16'h0000, cur_ff.fbegin};
          dual_field_pkg::fetch_window_end_addr:     nxt_cur.rdata = {16'h0000, cur_ff.fend};
          dual_field_pkg::odd_plane_line_skip_addr:  nxt_cur.rdata = {16'h0000, cur_ff.odd_skip};
          dual_field_pkg::even_plane_line_skip_addr: nxt_cur.rdata = {16'h0000, cur_ff.even_skip};
          dual_field_pkg::odd_field_pointer_addr:    nxt_cur.rdata = cur_ff.odd_cur;
          dual_field_pkg::even_field_pointer_addr:   nxt_cur.rdata = cur_ff.even_cur;
          dual_field_pkg::vertical_position_read_addr:
            nxt_cur.rdata = {16'h0000, cur_ff.long_frame_flag, cur_ff.vpos}; // RULE_15
          dual_field_pkg::pixel_data_addr:
            nxt_cur.rdata = {27'h0000000, cur_ff.pindex};
          default: nxt_cur.rdata = dual_field_pkg::ahb_zero;
        endcase
      end
    end

    // ----------------------------------------------------------
    // Line and frame: each field advances by its own skip
    // ----------------------------------------------------------
    if (line_end) begin
      nxt_cur.odd_cur  = 32'(cur_ff.odd_cur + skip_extend(cur_ff.odd_skip)); // RULE_12
      nxt_cur.even_cur = 32'(cur_ff.even_cur + skip_extend(cur_ff.even_skip));
      nxt_cur.vpos     = 15'(cur_ff.vpos + 1'b1);
    end
    if (frame_end) begin
      nxt_cur.odd_cur  = cur_ff.odd_ptr;
      nxt_cur.even_cur = cur_ff.even_ptr;
      nxt_cur.vpos     = 15'h0000;
      if (cur_ff.ctl0[dual_field_pkg::interlace_bit]) begin
        nxt_cur.long_frame_flag = ~nxt_cur.long_frame_flag; // RULE_15
      end
    end

    // ----------------------------------------------------------
    // Pixel state
    // ----------------------------------------------------------
    nxt_cur.pvalid = 1'b0;
    case (cur_ff.st)
      dual_field_pkg::st_idle: begin
        if (pix.valid) begin
          nxt_cur.st = dual_field_pkg::st_shift;
        end
      end
      dual_field_pkg::st_shift: begin
        if (!pix.valid) begin
          nxt_cur.st = dual_field_pkg::st_idle;
        end
      end
      default: nxt_cur.st = dual_field_pkg::st_idle;
    endcase

    // ----------------------------------------------------------
    // Colour priority
    // ----------------------------------------------------------
    if (pix.valid) begin
      planes = pix.data & plane_mask(cur_ff.ctl0[dual_field_pkg::plane_count_lsb +: 3], hi);
      nxt_cur.odd_dly  = {cur_ff.odd_dly[14:0], planes[4], planes[2], planes[0]}; // RULE_02
      nxt_cur.even_dly = {cur_ff.even_dly[14:0], planes[5], planes[3], planes[1]};
      odd_now  = scroll_pick(nxt_cur.odd_dly,
                   cur_ff.ctl1[dual_field_pkg::odd_scroll_lsb +: 4]); // RULE_11
      even_now = scroll_pick(nxt_cur.even_dly,
                   cur_ff.ctl1[dual_field_pkg::even_scroll_lsb +: 4]); // RULE_11
      if (dual) begin
        f1 = odd_now; // RULE_05
        f2 = even_now; // RULE_06
        if (hi) begin
          f1[2] = 1'b0; // RULE_08
          f2[2] = 1'b0; // RULE_08
        end
        c1 = {2'b00, f1};
        c2 = {2'b01, f2};
        if (cur_ff.ctl2[dual_field_pkg::second_field_front_bit]) begin
          front = layer_pick(c2, c1); // RULE_09
        end else begin
          front = layer_pick(c1, c2); // RULE_07
        end
        if (front == 5'h00 && object_valid) begin
          front = object_index; // RULE_07
        end
      end else begin
        front = {odd_now[2], even_now[1], odd_now[1], even_now[0], odd_now[0]}; // RULE_18
        if (front == 5'h00 && object_valid) begin
          front = object_index;
        end
      end
      nxt_cur.pvalid = 1'b1;
      nxt_cur.pindex = front; // RULE_17
    end
  end

  assign pix.ready = 1'b1;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cur_ff      <= '0;
      cur_ff.ctl0 <= dual_field_pkg::control_reset;
      cur_ff.st   <= dual_field_pkg::st_idle;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata          <= dual_field_pkg::ahb_zero;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      pixel_valid     <= 1'b0;
      pixel_index     <= 5'h00;
      odd_fetch_addr  <= dual_field_pkg::pointer_reset;
      even_fetch_addr <= dual_field_pkg::pointer_reset;
      fetch_begin     <= 9'h000;
      fetch_end       <= 9'h000;
    end else begin
      hrdata          <= nxt_cur.rdata;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      pixel_valid     <= nxt_cur.pvalid;
      pixel_index     <= nxt_cur.pindex;
      odd_fetch_addr  <= nxt_cur.odd_cur;
      even_fetch_addr <= nxt_cur.even_cur;
      fetch_begin     <= nxt_cur.fbegin[8:0]; // RULE_10
      fetch_end       <= nxt_cur.fend[8:0]; // RULE_10
    end
  end

endmodule : dual_field_pixel

// file: inc/dual_field_pkg.sv
// Package: register map, field positions, reset values and shared types
package dual_field_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] plane_control_zero_addr   = 8'h00;
  localparam logic [7:0] plane_control_one_addr    = 8'h04;
  localparam logic [7:0] plane_control_two_addr    = 8'h08;
  localparam logic [7:0] fetch_window_begin_addr   = 8'h0c;
  localparam logic [7:0] fetch_window_end_addr     = 8'h10;
  localparam logic [7:0] odd_plane_line_skip_addr  = 8'h14;
  localparam logic [7:0] even_plane_line_skip_addr = 8'h18;
  localparam logic [7:0] odd_field_pointer_addr    = 8'h1c;
  localparam logic [7:0] even_field_pointer_addr   = 8'h20;
  localparam logic [7:0] vertical_position_read_addr = 8'h24;
  localparam logic [7:0] pixel_data_addr           = 8'h28;
  localparam logic [7:0] frame_control_addr        = 8'h2c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int hires_bit              = 15;
  localparam int plane_count_lsb        = 12;
  localparam int dual_field_select_bit  = 10;
  localparam int interlace_bit          = 2;
  localparam int second_field_front_bit = 6;
  localparam int long_frame_flag_bit    = 15;
  localparam int odd_scroll_lsb         = 0;
  localparam int even_scroll_lsb        = 4;
  localparam int frame_toggle_bit       = 0;

  // ------------------------------------------------------------
  // Reset values and widths
  // ------------------------------------------------------------
  localparam logic [15:0] control_reset  = 16'h0000;
  localparam logic [31:0] pointer_reset  = 32'h0000_0000;
  localparam logic [31:0] ahb_zero       = 32'h0000_0000;
  localparam int          plane_max      = 6;
  localparam int          palette_width  = 5;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_shift = 2'b01
  } pix_state_e;

endpackage : dual_field_pkg

// file: inc/pixel_stream_if.sv
// Interface: pixel plane words between FIFO and pixel engine
interface pixel_stream_if #(parameter int WIDTH = 6);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : pixel_stream_if

// file: rtl/plane_fifo.sv
// Module: synchronous FIFO with registered read data
module plane_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  pixel_stream_if.source        out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             in_ready_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;
  logic             load;

  assign in_ready  = in_ready_ff;
  assign nxt_cnt   = (AW+1)'(cnt_ff + push - pop);
  assign push      = in_valid && in_ready;
  assign load      = (cnt_ff != '0) && (!out_valid_ff || out.ready);
  assign pop       = load;
  assign out.valid = out_valid_ff;
  assign out.data  = out_data_ff;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ff        <= '0;
      rd_ff        <= '0;
      cnt_ff       <= '0;
      in_ready_ff  <= 1'b1;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else begin
      if (push) begin
        wr_ff <= AW'(wr_ff + 1'b1);
      end
      if (pop) begin
        rd_ff       <= AW'(rd_ff + 1'b1);
        out_data_ff <= mem_ff[rd_ff];
      end
      if (load) begin
        out_valid_ff <= 1'b1;
      end else if (out.ready) begin
        out_valid_ff <= 1'b0;
      end
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule : plane_fifo

// file: testbench/dual_field_asserts.sv
// Checker: pixel ranges, fetch window and long-frame flag on top ports
module dual_field_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        plane_valid,
  input wire logic        plane_ready,
  input wire logic        object_valid,
  input wire logic        frame_end,
  input wire logic        pixel_valid,
  input wire logic [4:0]  pixel_index,
  input wire logic [8:0]  fetch_begin,
  input wire logic [8:0]  fetch_end
);
  logic        req;
  logic        w_ff;
  logic [7:0]  a_ff;
  logic [15:0] ctl0_ff;
  logic        lf_ff;
  logic        dual;
  logic        hires;
  logic [2:0]  cnt;
  assign req   = hsel && hready && htrans[1];
  assign dual  = ctl0_ff[dual_field_pkg::dual_field_select_bit];
  assign hires = ctl0_ff[dual_field_pkg::hires_bit];
  assign cnt   = ctl0_ff[dual_field_pkg::plane_count_lsb +: 3];

  // Shadow of mode register and long-frame flag
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      w_ff    <= 1'b0;
      a_ff    <= 8'h00;
      ctl0_ff <= 16'h0000;
      lf_ff   <= 1'b0;
    end else begin
      w_ff <= req && hwrite;
      a_ff <= haddr[7:0];
      if (w_ff && a_ff == dual_field_pkg::plane_control_zero_addr) begin
        ctl0_ff <= hwdata[15:0];
      end
      if ((w_ff && a_ff == dual_field_pkg::frame_control_addr && hwdata[0])
          ^ (frame_end && ctl0_ff[dual_field_pkg::interlace_bit])) begin
        lf_ff <= !lf_ff;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_win(logic [7:0] adr, logic [8:0] win);
    req && hwrite && haddr[7:0] == adr |=> ##1 win == $past(hwdata[8:0]);
  endproperty

  chk_push_gives_pixel: assert property (
    plane_valid && plane_ready |-> ##[1:16] pixel_valid) else $error("no pixel after push");
  chk_dual_range: assert property (
    pixel_valid && dual && !object_valid |-> pixel_index <= 5'h0f) else $error("dual range");
  chk_dual_no_eight: assert property (
    pixel_valid && dual && !object_valid |-> pixel_index != 5'h08) else $error("entry 8 shown");
  chk_hires_range: assert property (
    pixel_valid && dual && hires && !object_valid
    |-> pixel_index inside {[5'h00:5'h03], [5'h09:5'h0b]}) else $error("hires range");
  chk_single_range: assert property (
    pixel_valid && !dual && !object_valid && cnt <= 3'd5
    |-> {1'b0, pixel_index} < (6'h01 << cnt)) else $error("single range");
  chk_window_begin: assert property (
    p_win(dual_field_pkg::fetch_window_begin_addr, fetch_begin)) else $error("begin");
  chk_window_end: assert property (
    p_win(dual_field_pkg::fetch_window_end_addr, fetch_end)) else $error("end");
  chk_long_flag_read: assert property (
    req && !hwrite && haddr[7:0] == dual_field_pkg::vertical_position_read_addr
    |=> hrdata[15] == $past(lf_ff)) else $error("long flag");

  cov_dual_pixel: cover property (pixel_valid && dual && pixel_index > 5'h08);
  cov_hires_pixel: cover property (pixel_valid && dual && hires);
  cov_long_read: cover property (req && !hwrite && lf_ff);
endmodule : dual_field_asserts

bind dual_field_pixel dual_field_asserts i_dual_field_asserts (
  .sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .plane_valid, .plane_ready, .object_valid, .frame_end, .pixel_valid,
  .pixel_index, .fetch_begin, .fetch_end
);

// file: testbench/tb.sv
// Testbench: register access, pixel sweeps and long-frame flag
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        plane_valid;
  logic        plane_ready;
  logic [5:0]  plane_bits;
  logic        object_valid;
  logic [4:0]  object_index;
  logic        line_end;
  logic        frame_end;
  logic        pixel_valid;
  logic [4:0]  pixel_index;
  logic [8:0]  fetch_begin;
  logic [8:0]  fetch_end;
  logic [31:0] odd_fetch_addr;
  logic [31:0] even_fetch_addr;
  logic [31:0] rd;
  logic        dl;
  logic        pr;
  logic [5:0]  mk;
  logic [5:0]  pm;
  logic        sc;
  logic [4:0]  got[$];
  logic [4:0]  want[$];
  int          n_errors;
  int          n_compared;

  assign hready = hreadyout;

  dual_field_pixel #(.FIFO_DEPTH(8)) i_dual_field_pixel (
    .sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .plane_valid, .plane_ready, .plane_bits,
    .object_valid, .object_index, .line_end, .frame_end, .pixel_valid,
    .pixel_index, .odd_fetch_addr, .even_fetch_addr, .fetch_begin, .fetch_end
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (pixel_valid === 1'b1) begin
      got.push_back(pixel_index);
    end
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic tout();
    n_errors++;
    close_out();
  endtask : tout

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) tout();
  endtask : edge_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    edge_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rc

  task automatic push(input logic [5:0] w);
    int n;
    plane_bits  <= w;
    plane_valid <= 1'b1;
    n = 0;
    @(negedge sys_clk);
    while (plane_ready !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    if (n >= 50) tout();
  endtask : push

  function automatic logic [4:0] model(input logic [5:0] pb);
    logic [5:0] m;
    logic [2:0] f1;
    logic [2:0] f2;
    logic [4:0] bg;
    m  = ((pb & mk) & 6'h2a) | ((sc ? pm : (pb & mk)) & 6'h15);
    f1 = {m[4], m[2], m[0]};
    f2 = {m[5], m[3], m[1]};
    bg = object_valid ? object_index : 5'h00;
    if (!dl) return (m[4:0] != 5'h00) ? m[4:0] : bg;
    if (f2 != 3'h0 && (pr || f1 == 3'h0)) return {2'b01, f2};
    return (f1 != 3'h0) ? {2'b00, f1} : bg;
  endfunction : model

  task automatic sweep(input logic h, input logic d, input logic p,
                       input logic [2:0] c, input int n);
    int k;
    dl  = d;
    pr  = p;
    mk  = ~(6'h3f << ((h && c > 3'd4) ? 3'd4 : c));
    bus(1'b1, dual_field_pkg::plane_control_zero_addr, {16'h0000, h, c, 1'b0, d, 10'h000});
    bus(1'b1, dual_field_pkg::plane_control_two_addr, {25'h0000000, p, 6'h00});
    got.delete();
    want.delete();
    for (k = 0; k < n; k++) begin
      push(k[5:0]);
      want.push_back(model(k[5:0]));
      pm = k[5:0] & mk;
    end
    plane_valid <= 1'b0;
    k = 0;
    while (got.size() < n && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 200) tout();
    for (k = 0; k < n; k++) chk({27'h0, got[k]}, {27'h0, want[k]});
  endtask : sweep

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn         = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0000_0000;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0000_0000;
    plane_valid  = 1'b0;
    plane_bits   = 6'h00;
    object_valid = 1'b0;
    object_index = 5'h00;
    line_end     = 1'b0;
    frame_end    = 1'b0;
    n_errors     = 0;
    n_compared   = 0;
    mk           = 6'h00;
    pm           = 6'h00;
    sc           = 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rc(a[7:0], 32'h0000_0000);
    bus(1'b0, dual_field_pkg::vertical_position_read_addr, 32'h0000_0000);
    chk({31'h0, rd[15]}, 32'h0000_0000);
    for (int a = 12; a <= 32; a += 4) begin
      bus(1'b1, a[7:0], 32'h0000_0081 + a);
      rc(a[7:0], (32'h0000_0081 + a) & {31'h7fff_ffff, a < 28});
    end
    chk({23'h0, fetch_begin}, 32'h0000_008d);
    chk({23'h0, fetch_end}, 32'h0000_0091);
    bus(1'b1, 8'h30, 32'h0000_ffff);
    rc(8'h30, 32'h0000_0000);
    bus(1'b1, dual_field_pkg::fetch_window_begin_addr, 32'h0000_0030);
    bus(1'b1, dual_field_pkg::even_plane_line_skip_addr, 32'h0000_fffe);
    rc(dual_field_pkg::even_plane_line_skip_addr, 32'h0000_fffe);
    line_end <= 1'b1;
    @(posedge sys_clk);
    line_end <= 1'b0;
    @(posedge sys_clk);
    chk(odd_fetch_addr, 32'h0000_0131);
    chk(even_fetch_addr, 32'h0000_009e);
    chk({31'h0, hresp}, 32'h0000_0000);
    sweep(1'b0, 1'b1, 1'b0, 3'd6, 64);
    sweep(1'b0, 1'b1, 1'b1, 3'd6, 64);
    sweep(1'b0, 1'b1, 1'b0, 3'd2, 16);
    sweep(1'b1, 1'b1, 1'b1, 3'd6, 64);
    sweep(1'b0, 1'b0, 1'b0, 3'd5, 32);
    bus(1'b1, dual_field_pkg::plane_control_one_addr, 32'h0000_0001);
    sc = 1'b1;
    sweep(1'b0, 1'b1, 1'b0, 3'd6, 64);
    object_valid <= 1'b1;
    object_index <= 5'h13;
    sweep(1'b0, 1'b1, 1'b0, 3'd6, 64);
    sweep(1'b0, 1'b0, 1'b1, 3'd5, 8);
    bus(1'b1, dual_field_pkg::plane_control_zero_addr, 32'h0000_0004);
    frame_end <= 1'b1;
    line_end  <= 1'b1;
    @(posedge sys_clk);
    frame_end <= 1'b0;
    line_end  <= 1'b0;
    bus(1'b0, dual_field_pkg::vertical_position_read_addr, 32'h0000_0000);
    chk({31'h0, rd[15]}, 32'h0000_0001);
    chk(odd_fetch_addr, 32'h0000_009c);
    bus(1'b1, dual_field_pkg::frame_control_addr, 32'h0000_0001);
    bus(1'b0, dual_field_pkg::vertical_position_read_addr, 32'h0000_0000);
    chk({31'h0, rd[15]}, 32'h0000_0000);
    close_out();
  end
endmodule : tb
